// ==== cdp_comparator.sv ====
// digital control and output path of one analog comparator channel
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/10ps

module cdp_comparator (
	input wire logic i_clk, // 40 MHz system clock
	input wire logic i_rst_n, // synchronous reset, active low
	input wire logic [cdp_pkg::ADDR_W-1:0] i_addr, // register address
	input wire logic [cdp_pkg::DATA_W-1:0] i_wdata, // write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	output logic [cdp_pkg::DATA_W-1:0] o_rdata, // read data, cycle after strobe
	input wire logic i_cmp_raw, // raw analog comparator output
	input wire logic i_pwm_clk_en, // one-cycle PWM clock tick
	input wire logic i_idle, // device in Idle mode
	input wire logic i_sleep, // device in Sleep mode
	input wire logic i_other_idle_stop, // OR of other channels' idle_stop
	output logic o_idle_stop, // this channel's idle_stop
	output logic o_comparator_on, // analog comparator enable
	output logic [2:0] o_src_sel, // input mux code
	output logic [1:0] o_hyst_amount, // hysteresis amount code
	output logic o_hyst_edge, // hysteresis edge select
	output logic o_ext_ref_sel, // DAC reference from external pin
	output logic o_full_scale, // DAC full scale select
	output logic o_ref_out_en, // DAC to reference output pin
	output logic [cdp_pkg::THR_W-1:0] o_threshold, // DAC threshold code
	output logic o_event, // filtered event level, registered from the filter output
	output logic o_irq, // interrupt request pulse
	output logic o_adc_trig, // ADC trigger pulse
	output logic o_wake // wake-up pulse
);
	import cdp_pkg::*;

	logic [DATA_W-1:0] ctrl_q;
	logic [DATA_W-1:0] thr_q;
	logic [DATA_W-1:0] rdata_q;
	logic [2:0] src_q;
	logic [1:0] str_cnt_q;
	logic [1:0] flt_cnt_q;
	logic filt_q;
	logic irq_q;
	logic adc_q;
	logic wake_q;
	logic pol;
	logic stretched;
	logic halt;
	logic run;
	logic tick;
	logic wr_ctrl;
	logic wr_thr;

	function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] r);
		hit = strobe && (a == r);
	endfunction : hit

	assign wr_ctrl = hit(i_wr, i_addr, CTRL_ADDR);
	assign wr_thr = hit(i_wr, i_addr, THR_ADDR);

	// control register, bit 14 and state bit never stored
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= i_wdata & CTRL_WMASK;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			thr_q <= THR_RESET;
		end else if (wr_thr) begin
			thr_q <= i_wdata & THR_WMASK;
		end
	end

	// read data stand one cycle, zero otherwise and for unmapped addresses
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rdata_q <= '0;
		end else if (hit(i_rd, i_addr, CTRL_ADDR)) begin
			rdata_q <= ctrl_q | (DATA_W'(pol) << B_STATE);
		end else if (hit(i_rd, i_addr, THR_ADDR)) begin
			rdata_q <= thr_q;
		end else begin
			rdata_q <= '0;
		end
	end

	// input multiplexer code
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			src_q <= SRC_PIN_A;
		end else if (!ctrl_q[B_ALT_IN]) begin
			src_q <= {1'b0, ctrl_q[B_INSEL_HI:B_INSEL_LO]};
		end else if (ctrl_q[B_INSEL_HI:B_INSEL_LO] == INSEL_AMP1) begin
			src_q <= SRC_AMP1;
		end else if (ctrl_q[B_INSEL_HI:B_INSEL_LO] == INSEL_AMP2) begin
			src_q <= SRC_AMP2;
		end else begin
			src_q <= SRC_NONE;
		end
	end

	assign pol = i_cmp_raw ^ ctrl_q[B_INVERT];
	assign halt = i_idle && (ctrl_q[B_IDLE_STOP] || i_other_idle_stop);
	assign run = ctrl_q[B_ON] && !halt;
	assign tick = run && (!ctrl_q[B_FCLK_SEL] || i_pwm_clk_en);

	// stretcher output rises with the event, counter holds it afterwards
	assign stretched = ctrl_q[B_ON] && (pol || (str_cnt_q != CNT_ZERO));

	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !ctrl_q[B_ON]) begin
			str_cnt_q <= CNT_ZERO;
		end else if (pol) begin
			str_cnt_q <= STRETCH_TICKS;
		end else if (tick && (str_cnt_q != CNT_ZERO)) begin
			str_cnt_q <= str_cnt_q - CNT_ONE;
		end
	end

	// stability filter on the stretched signal
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !ctrl_q[B_ON]) begin
			flt_cnt_q <= CNT_ZERO;
			filt_q <= 1'b0;
		end else if (!ctrl_q[B_FLT_EN] && !halt) begin
			flt_cnt_q <= CNT_ZERO;
			filt_q <= stretched;
		end else if (stretched == filt_q) begin
			flt_cnt_q <= CNT_ZERO;
		end else if (tick) begin
			if (flt_cnt_q == FILT_TICKS - CNT_ONE) begin
				flt_cnt_q <= CNT_ZERO;
				filt_q <= stretched;
			end else begin
				flt_cnt_q <= flt_cnt_q + CNT_ONE;
			end
		end
	end

	// event fan-out, all consumers in the same cycle
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			irq_q <= 1'b0;
			adc_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			irq_q <= filt_q && !o_event;
			adc_q <= filt_q && !o_event;
			wake_q <= filt_q && !o_event && (i_sleep || i_idle);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_event <= 1'b0;
		end else begin
			o_event <= filt_q;
		end
	end

	assign o_rdata = rdata_q;
	assign o_idle_stop = ctrl_q[B_IDLE_STOP];
	assign o_comparator_on = ctrl_q[B_ON];
	assign o_src_sel = src_q;
	assign o_hyst_amount = ctrl_q[B_HYST_HI:B_HYST_LO];
	assign o_hyst_edge = ctrl_q[B_HYST_EDGE];
	assign o_ext_ref_sel = ctrl_q[B_EXT_REF];
	assign o_full_scale = ctrl_q[B_FULL_SCALE];
	assign o_ref_out_en = ctrl_q[B_REF_OE];
	assign o_threshold = thr_q[THR_W-1:0];
	assign o_irq = irq_q;
	assign o_adc_trig = adc_q;
	assign o_wake = wake_q;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	property p_stretch_rise;
		pol && ctrl_q[B_ON] |-> stretched;
	endproperty
	a_stretch_rise: assert property (p_stretch_rise) else $error("stretcher missed event");

	property p_stretch_hold;
		(pol && ctrl_q[B_ON] && !wr_ctrl) ##1 (ctrl_q[B_ON] && !wr_ctrl)[*2] |-> stretched;
	endproperty
	a_stretch_hold: assert property (p_stretch_hold) else $error("stretch too short");

	property p_filter_stable;
		$changed(filt_q) && $past(ctrl_q[B_FLT_EN]) && $past(ctrl_q[B_ON])
			|-> $past(flt_cnt_q) == FILT_TICKS - CNT_ONE && $past(tick) && filt_q == $past(stretched);
	endproperty
	a_filter_stable: assert property (p_filter_stable) else $error("filter passed early");

	property p_bypass;
		!ctrl_q[B_FLT_EN] && ctrl_q[B_ON] && !halt |=> filt_q == $past(stretched);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass not followed");

	property p_pwm_tick;
		ctrl_q[B_FCLK_SEL] && !i_pwm_clk_en |-> !tick;
	endproperty
	a_pwm_tick: assert property (p_pwm_tick) else $error("tick without pwm clock");

	property p_state_read;
		hit(i_rd, i_addr, CTRL_ADDR)
			|=> o_rdata[B_STATE] == ($past(i_cmp_raw) ^ $past(ctrl_q[B_INVERT]));
	endproperty
	a_state_read: assert property (p_state_read) else $error("state bit wrong");

	property p_off;
		!ctrl_q[B_ON] |=> !filt_q ##1 !o_event;
	endproperty
	a_off: assert property (p_off) else $error("event while off");

	property p_idle_halt;
		i_idle && (ctrl_q[B_IDLE_STOP] || i_other_idle_stop) |-> !tick;
	endproperty
	a_idle_halt: assert property (p_idle_halt) else $error("ran during idle stop");

	property p_thr_read;
		hit(i_rd, i_addr, THR_ADDR)
			|=> o_rdata[15:12] == 4'h0 && o_rdata[11:0] == $past(thr_q[11:0]);
	endproperty
	a_thr_read: assert property (p_thr_read) else $error("threshold read wrong");

	property p_unimp;
		wr_ctrl |=> !ctrl_q[B_UNIMP] ##1 o_rdata[B_UNIMP] == 1'b0;
	endproperty
	a_unimp: assert property (p_unimp) else $error("bit 14 not zero");

	property p_fanout;
		$rose(filt_q) |=> o_event && o_irq && o_adc_trig;
	endproperty
	a_fanout: assert property (p_fanout) else $error("consumers not concurrent");

	property p_wake;
		$rose(filt_q) && (i_sleep || i_idle) |=> o_wake;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake-up");

	property p_irq_edge;
		o_irq |-> o_event && !$past(o_event) ##1 !o_irq;
	endproperty
	a_irq_edge: assert property (p_irq_edge) else $error("interrupt not on edge");

	property p_src;
		!ctrl_q[B_ALT_IN] && !wr_ctrl |=> o_src_sel == {1'b0, $past(ctrl_q[7:6])};
	endproperty
	a_src: assert property (p_src) else $error("pin select wrong");

	property p_stretch_load;
		pol && ctrl_q[B_ON] |=> str_cnt_q == STRETCH_TICKS;
	endproperty
	a_stretch_load: assert property (p_stretch_load) else $error("stretch count not loaded");

	property p_stretch_count;
		ctrl_q[B_ON] && !pol && tick && str_cnt_q != CNT_ZERO
			|=> str_cnt_q == $past(str_cnt_q) - CNT_ONE;
	endproperty
	a_stretch_count: assert property (p_stretch_count) else $error("stretch count wrong");

	property p_stretch_end;
		$fell(stretched) && ctrl_q[B_ON] && $past(ctrl_q[B_ON]) && $past(i_rst_n)
			|-> $past(str_cnt_q) == CNT_ONE && $past(tick);
	endproperty
	a_stretch_end: assert property (p_stretch_end) else $error("stretch ended early");

	property p_filter_clear;
		ctrl_q[B_ON] && ctrl_q[B_FLT_EN] && stretched == filt_q |=> flt_cnt_q == CNT_ZERO;
	endproperty
	a_filter_clear: assert property (p_filter_clear) else $error("filter count not cleared");

	property p_filter_count;
		ctrl_q[B_ON] && ctrl_q[B_FLT_EN] && stretched != filt_q && tick && flt_cnt_q != CNT_ZERO + CNT_ONE + CNT_ONE
			|=> flt_cnt_q == $past(flt_cnt_q) + CNT_ONE && $stable(filt_q);
	endproperty
	a_filter_count: assert property (p_filter_count) else $error("filter count wrong");

	property p_filter_hold;
		ctrl_q[B_ON] && ctrl_q[B_FLT_EN] && !tick |=> $stable(filt_q);
	endproperty
	a_filter_hold: assert property (p_filter_hold) else $error("filter moved without tick");

	property p_filter_input;
		$changed(filt_q) && $past(ctrl_q[B_ON]) && $past(i_rst_n)
			|-> filt_q == $past(stretched);
	endproperty
	a_filter_input: assert property (p_filter_input) else $error("filter input not stretcher");

	property p_off_stretch;
		!ctrl_q[B_ON] |-> !stretched ##1 str_cnt_q == CNT_ZERO;
	endproperty
	a_off_stretch: assert property (p_off_stretch) else $error("stretcher active while off");

	property p_halt_freeze;
		halt && ctrl_q[B_ON] |=> $stable(filt_q);
	endproperty
	a_halt_freeze: assert property (p_halt_freeze) else $error("filter moved in idle stop");

	property p_halt_count;
		halt && ctrl_q[B_ON] && !pol |=> $stable(str_cnt_q);
	endproperty
	a_halt_count: assert property (p_halt_count) else $error("stretcher moved in idle stop");

	property p_sys_tick;
		ctrl_q[B_ON] && !ctrl_q[B_FCLK_SEL] && !halt |-> tick;
	endproperty
	a_sys_tick: assert property (p_sys_tick) else $error("system clock tick missing");

	property p_pwm_follow;
		ctrl_q[B_ON] && ctrl_q[B_FCLK_SEL] && !halt && i_pwm_clk_en |-> tick;
	endproperty
	a_pwm_follow: assert property (p_pwm_follow) else $error("pwm clock tick missing");

	property p_pwm_stretch;
		ctrl_q[B_ON] && ctrl_q[B_FCLK_SEL] && !i_pwm_clk_en && !pol
			|=> $stable(str_cnt_q);
	endproperty
	a_pwm_stretch: assert property (p_pwm_stretch) else $error("stretcher ran off pwm clock");

	property p_invert;
		ctrl_q[B_ON] && (i_cmp_raw != ctrl_q[B_INVERT]) |-> stretched;
	endproperty
	a_invert: assert property (p_invert) else $error("polarity not applied");

	property p_ctrl_write;
		wr_ctrl |=> o_comparator_on == $past(i_wdata[B_ON]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("enable bit not written");

	property p_hyst;
		wr_ctrl |=> o_hyst_amount == $past(i_wdata[B_HYST_HI:B_HYST_LO]);
	endproperty
	a_hyst: assert property (p_hyst) else $error("hysteresis amount wrong");

	property p_hyst_edge;
		wr_ctrl |=> o_hyst_edge == $past(i_wdata[B_HYST_EDGE]);
	endproperty
	a_hyst_edge: assert property (p_hyst_edge) else $error("hysteresis edge wrong");

	property p_ext_ref;
		wr_ctrl |=> o_ext_ref_sel == $past(i_wdata[B_EXT_REF]);
	endproperty
	a_ext_ref: assert property (p_ext_ref) else $error("reference select wrong");

	property p_thr_write;
		wr_thr |=> o_threshold == $past(i_wdata[THR_W-1:0]);
	endproperty
	a_thr_write: assert property (p_thr_write) else $error("threshold code wrong");

	property p_alt_amp1;
		ctrl_q[B_ALT_IN] && ctrl_q[B_INSEL_HI:B_INSEL_LO] == INSEL_AMP1
			|=> o_src_sel == SRC_AMP1;
	endproperty
	a_alt_amp1: assert property (p_alt_amp1) else $error("first amplifier not chosen");

	property p_alt_amp2;
		ctrl_q[B_ALT_IN] && ctrl_q[B_INSEL_HI:B_INSEL_LO] == INSEL_AMP2
			|=> o_src_sel == SRC_AMP2;
	endproperty
	a_alt_amp2: assert property (p_alt_amp2) else $error("second amplifier not chosen");

endmodule : cdp_comparator

// ==== cdp_pkg.sv ====
// constants shared by the comparator digital path
package cdp_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
	localparam logic [ADDR_W-1:0] THR_ADDR = 4'h1;
	localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] THR_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] CTRL_WMASK = 16'hBFF7;
	localparam logic [DATA_W-1:0] THR_WMASK = 16'h0FFF;
	localparam int THR_W = 12;
	localparam int B_ON = 15;
	localparam int B_UNIMP = 14;
	localparam int B_IDLE_STOP = 13;
	localparam int B_HYST_HI = 12;
	localparam int B_HYST_LO = 11;
	localparam int B_FLT_EN = 10;
	localparam int B_FCLK_SEL = 9;
	localparam int B_REF_OE = 8;
	localparam int B_INSEL_HI = 7;
	localparam int B_INSEL_LO = 6;
	localparam int B_EXT_REF = 5;
	localparam int B_HYST_EDGE = 4;
	localparam int B_STATE = 3;
	localparam int B_ALT_IN = 2;
	localparam int B_INVERT = 1;
	localparam int B_FULL_SCALE = 0;
	localparam logic [1:0] STRETCH_TICKS = 2'h3;
	localparam logic [1:0] FILT_TICKS = 2'h3;
	localparam logic [1:0] CNT_ONE = 2'h1;
	localparam logic [1:0] CNT_ZERO = 2'h0;
	localparam logic [2:0] SRC_PIN_A = 3'h0;
	localparam logic [2:0] SRC_AMP1 = 3'h4;
	localparam logic [2:0] SRC_AMP2 = 3'h5;
	localparam logic [2:0] SRC_NONE = 3'h7;
	localparam logic [1:0] INSEL_AMP1 = 2'h0;
	localparam logic [1:0] INSEL_AMP2 = 2'h1;
endpackage : cdp_pkg

// ==== cdp_analog_model.sv ====
// analog front end and PWM clock source for the comparator bench
`timescale 1ns/10ps
module cdp_analog_model #(
	parameter int PWM_DIV = 8
) (
	input wire logic i_clk, // system clock
	input wire logic i_level, // requested comparator output level
	output logic o_cmp_raw, // raw comparator output
	output logic o_pwm_tick // one-cycle PWM clock tick
);
	logic [7:0] div_q = 8'h00;
	assign o_cmp_raw = i_level;
	always_ff @(posedge i_clk) begin
		div_q <= (div_q == 8'(PWM_DIV - 1)) ? 8'h00 : div_q + 8'h01;
	end
	assign o_pwm_tick = (div_q == 8'h00);
endmodule : cdp_analog_model

// ==== tb_comparator_digital_path.sv ====
// self-checking bench for the comparator digital path
`timescale 1ns/10ps
`define CDP_CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fails++; \
	$display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module tb_comparator_digital_path;
	import cdp_pkg::*;
	logic clk, rst_n, wr, rd, level, idle, sleep, other_stop, raw, tick;
	logic idle_stop, on, hedge, ext_ref, full, ref_oe, ev, irq, adc, wake;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, d;
	logic [2:0] src, k3, exp_src;
	logic [1:0] hyst;
	logic [THR_W-1:0] thr;
	int fails = 0;
	int checks_done = 0;
	int lat, n;
	cdp_analog_model #(.PWM_DIV(8)) model (.i_clk(clk), .i_level(level), .o_cmp_raw(raw),
		.o_pwm_tick(tick));
	cdp_comparator dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cmp_raw(raw), .i_pwm_clk_en(tick),
		.i_idle(idle), .i_sleep(sleep), .i_other_idle_stop(other_stop),
		.o_idle_stop(idle_stop), .o_comparator_on(on), .o_src_sel(src),
		.o_hyst_amount(hyst), .o_hyst_edge(hedge), .o_ext_ref_sel(ext_ref),
		.o_full_scale(full), .o_ref_out_en(ref_oe), .o_threshold(thr), .o_event(ev),
		.o_irq(irq), .o_adc_trig(adc), .o_wake(wake));
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg
	task automatic rd_reg(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	task automatic meas(input logic lvl);
		@(posedge clk);
		level <= lvl;
		lat = 0;
		do begin
			@(posedge clk);
			#1 lat++;
		end while (ev !== lvl && lat < 200);
	endtask : meas
	task automatic give_verdict;
		if (fails == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#(25 * 6000);
		fails++;
		give_verdict();
	end
	initial begin
		{rst_n, wr, rd, level, idle, sleep, other_stop} = '0;
		addr = '0;
		wdata = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(CTRL_ADDR);
		`CDP_CHK("ctrl reset", CTRL_RESET, d)
		rd_reg(THR_ADDR);
		`CDP_CHK("thr reset", THR_RESET, d)
		wr_reg(THR_ADDR, 16'hFFFF);
		`CDP_CHK("thr out", 12'hFFF, thr)
		rd_reg(THR_ADDR);
		`CDP_CHK("thr read", 16'h0FFF, d)
		rd_reg(4'hF);
		`CDP_CHK("unmapped", 16'h0000, d)
		// single channel, so reference output may be set
		wr_reg(CTRL_ADDR, 16'hFFFF);
		`CDP_CHK("ctrl outs", 8'hFF, {on, idle_stop, hyst, hedge, ext_ref, full, ref_oe})
		rd_reg(CTRL_ADDR);
		`CDP_CHK("ctrl read", 16'hBFFF, d)
		wr_reg(CTRL_ADDR, 16'h0003);
		`CDP_CHK("ctrl outs low", 8'h02, {on, idle_stop, hyst, hedge, ext_ref, full, ref_oe})
		rd_reg(CTRL_ADDR);
		`CDP_CHK("state inv", 16'h000B, d)
		level <= 1'b1;
		rd_reg(CTRL_ADDR);
		`CDP_CHK("state inv hi", 16'h0003, d)
		level <= 1'b0;
		for (int k = 0; k < 6; k++) begin
			k3 = 3'(k);
			exp_src = k3[2] ? (k3[1] ? SRC_NONE : {2'b10, k3[0]}) : {1'b0, k3[1:0]};
			wr_reg(CTRL_ADDR, {8'h80, k3[1:0], 3'b000, k3[2], 2'b01});
			@(posedge clk);
			#1 `CDP_CHK("source", exp_src, src)
		end
		wr_reg(CTRL_ADDR, 16'h8001);
		meas(1'b1);
		`CDP_CHK("bypass lat", 2, lat)
		`CDP_CHK("fanout", 3'b110, {irq, adc, wake})
		@(posedge clk);
		#1 `CDP_CHK("irq pulse", 1'b0, irq)
		meas(1'b0);
		@(posedge clk);
		level <= 1'b1;
		@(posedge clk);
		level <= 1'b0;
		n = 0;
		repeat (20) begin
			@(posedge clk);
			#1 n += int'(ev === 1'b1);
		end
		`CDP_CHK("stretch", 1'b1, n >= 3)
		wr_reg(CTRL_ADDR, 16'h8401);
		meas(1'b1);
		`CDP_CHK("filter lat", 4, lat)
		meas(1'b0);
		wr_reg(CTRL_ADDR, 16'h8601);
		sleep <= 1'b1;
		meas(1'b1);
		`CDP_CHK("pwm clock", 1'b1, lat > 16)
		`CDP_CHK("wake", 3'b111, {irq, adc, wake})
		sleep <= 1'b0;
		meas(1'b0);
		wr_reg(CTRL_ADDR, 16'h8401);
		other_stop <= 1'b1;
		idle <= 1'b1;
		@(posedge clk);
		level <= 1'b1;
		repeat (20) @(posedge clk);
		#1 `CDP_CHK("idle halt", 1'b0, ev)
		idle <= 1'b0;
		meas(1'b1);
		`CDP_CHK("idle resume", 1'b1, ev)
		wr_reg(CTRL_ADDR, 16'hA401);
		`CDP_CHK("idle stop bit", 1'b1, idle_stop)
		give_verdict();
	end
endmodule : tb_comparator_digital_path
